// ---- verilog/eil_pkg.sv ----
package eil_pkg;
  localparam int NLINE = 28;
  localparam int NPIN = 16;
  localparam int SEL_W = 3;
  localparam int ADDR_W = 8;
  typedef logic [NLINE-1:0] eil_lines_t;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EMASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RTEN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FTEN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SWTRIG = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PEND = 8'h14;

  // Reset values and implemented bits
  localparam logic [31:0] RST_IMASK = 32'h0f94_0000;
  localparam logic [31:0] RST_EMASK = 32'h0000_0000;
  localparam logic [31:0] RST_RTEN = 32'h0000_0000;
  localparam logic [31:0] RST_FTEN = 32'h0000_0000;
  localparam logic [31:0] RST_SWTRIG = 32'h0000_0000;
  localparam logic [31:0] RST_PEND = 32'h0000_0000;
  localparam logic [31:0] MASK_BITS = 32'h0fff_ffff;
  localparam logic [31:0] TRIG_BITS = 32'h006b_ffff;
  localparam logic [31:0] WAKE_BITS = 32'h0a80_0000;

  // Port select codes for lines 0 to 15
  localparam logic [SEL_W-1:0] SEL_PORT_A = 3'h0;
  localparam logic [SEL_W-1:0] SEL_PORT_B = 3'h1;
  localparam logic [SEL_W-1:0] SEL_PORT_C = 3'h2;
  localparam logic [SEL_W-1:0] SEL_PORT_D = 3'h3;
  localparam logic [SEL_W-1:0] SEL_PORT_F = 3'h4;

  // Internal line positions
  localparam int LN_SUPPLY = 16;
  localparam int LN_ALARM = 17;
  localparam int LN_TAMPER = 19;
  localparam int LN_CMP_FIRST = 21;
  localparam int LN_CMP_SECOND = 22;
  localparam int LN_I2C = 23;
  localparam int LN_USART = 25;
  localparam int LN_CONSUMER = 27;
endpackage

// ---- verilog/eil_line_sync.sv ----
`timescale 1ns/1ns
module eil_line_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [eil_pkg::NPIN-1:0] port_a_pins,
  input wire logic [eil_pkg::NPIN-1:0] port_b_pins,
  input wire logic [eil_pkg::NPIN-1:0] port_c_pins,
  input wire logic [eil_pkg::NPIN-1:0] port_d_pins,
  input wire logic [eil_pkg::NPIN-1:0] port_f_pins,
  input wire logic [eil_pkg::NPIN*eil_pkg::SEL_W-1:0] port_select,
  input wire logic supply_monitor_output,
  input wire logic clock_alarm,
  input wire logic tamper_stamp,
  input wire logic first_comparator,
  input wire logic second_comparator,
  input wire logic i2c_wake,
  input wire logic usart_wake,
  input wire logic consumer_control_wake,
  output eil_pkg::eil_lines_t line_sync
);
  import eil_pkg::*;

  typedef struct packed {
    logic [4:0][NPIN-1:0] pins;
    logic [NPIN*SEL_W-1:0] sel;
    logic [7:0] src;
  } eil_raw_t;

  typedef struct packed {
    eil_raw_t s1;
    eil_raw_t s2;
  } eil_sync_t;

  eil_sync_t q;
  eil_sync_t next_q;
  logic [NPIN-1:0] pin_line;

  // Raw inputs pass two stages before any logic; the select code is
  // quasi-static, a change of it may show one spurious edge
  always_comb begin
    next_q = q;
    next_q.s1.pins = {port_f_pins, port_d_pins, port_c_pins, port_b_pins, port_a_pins};
    next_q.s1.sel = port_select;
    next_q.s1.src = {consumer_control_wake, usart_wake, i2c_wake, second_comparator,
      first_comparator, tamper_stamp, clock_alarm, supply_monitor_output};
    next_q.s2 = q.s1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_pin
      logic [SEL_W-1:0] sel;
      assign sel = q.s2.sel[i*SEL_W +: SEL_W];
      // Pin n of the chosen port feeds line n
      assign pin_line[i] = (sel == SEL_PORT_A) ? q.s2.pins[0][i] :
                           (sel == SEL_PORT_B) ? q.s2.pins[1][i] :
                           (sel == SEL_PORT_C) ? q.s2.pins[2][i] :
                           (sel == SEL_PORT_D) ? q.s2.pins[3][i] :
                           (sel == SEL_PORT_F) ? q.s2.pins[4][i] : 1'b0;
    end
  endgenerate

  always_comb begin
    line_sync = '0;
    line_sync[NPIN-1:0] = pin_line;
    line_sync[LN_SUPPLY] = q.s2.src[0];
    line_sync[LN_ALARM] = q.s2.src[1];
    line_sync[LN_TAMPER] = q.s2.src[2];
    line_sync[LN_CMP_FIRST] = q.s2.src[3];
    line_sync[LN_CMP_SECOND] = q.s2.src[4];
    line_sync[LN_I2C] = q.s2.src[5];
    line_sync[LN_USART] = q.s2.src[6];
    line_sync[LN_CONSUMER] = q.s2.src[7];
  end
endmodule

// ---- verilog/eil_edge_detect.sv ----
`timescale 1ns/1ns
module eil_edge_detect (
  input wire logic clk_sys,
  input wire logic rst,
  input eil_pkg::eil_lines_t line_cur,
  output eil_pkg::eil_lines_t line_rise,
  output eil_pkg::eil_lines_t line_fall
);
  import eil_pkg::*;

  typedef struct packed {
    eil_lines_t prev;
  } eil_edge_t;

  eil_edge_t q;
  eil_edge_t next_q;

  always_comb begin
    next_q = q;
    next_q.prev = line_cur;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign line_rise = line_cur & ~q.prev;
  assign line_fall = ~line_cur & q.prev;

  edge_track_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 (line_rise == (line_cur & ~$past(line_cur))))
    else $error("rise does not follow previous sample");
endmodule

// ---- verilog/eil_controller.sv ----
`timescale 1ns/1ns
module eil_controller (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [eil_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [eil_pkg::NPIN-1:0] port_a_pins,
  input wire logic [eil_pkg::NPIN-1:0] port_b_pins,
  input wire logic [eil_pkg::NPIN-1:0] port_c_pins,
  input wire logic [eil_pkg::NPIN-1:0] port_d_pins,
  input wire logic [eil_pkg::NPIN-1:0] port_f_pins,
  input wire logic [eil_pkg::NPIN*eil_pkg::SEL_W-1:0] port_select,
  input wire logic supply_monitor_output,
  input wire logic clock_alarm,
  input wire logic tamper_stamp,
  input wire logic first_comparator,
  input wire logic second_comparator,
  input wire logic i2c_wake,
  input wire logic usart_wake,
  input wire logic consumer_control_wake,
  output eil_pkg::eil_lines_t line_irq,
  output logic irq_wake,
  output logic event_pulse
);
  import eil_pkg::*;

  typedef struct packed {
    eil_lines_t imask;
    eil_lines_t emask;
    eil_lines_t rten;
    eil_lines_t ften;
    eil_lines_t swtrig;
    eil_lines_t pend;
    logic [31:0] rdata;
    logic wake;
    logic evt;
  } eil_state_t;

  eil_state_t q;
  eil_state_t next_q;

  eil_lines_t line_sync;
  eil_lines_t line_rise;
  eil_lines_t line_fall;

  eil_line_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins),
    .port_c_pins(port_c_pins),
    .port_d_pins(port_d_pins),
    .port_f_pins(port_f_pins),
    .port_select(port_select),
    .supply_monitor_output(supply_monitor_output),
    .clock_alarm(clock_alarm),
    .tamper_stamp(tamper_stamp),
    .first_comparator(first_comparator),
    .second_comparator(second_comparator),
    .i2c_wake(i2c_wake),
    .usart_wake(usart_wake),
    .consumer_control_wake(consumer_control_wake),
    .line_sync(line_sync)
  );

  eil_edge_detect u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .line_cur(line_sync),
    .line_rise(line_rise),
    .line_fall(line_fall)
  );

  // Decoded accesses
  logic wr_imask;
  logic wr_emask;
  logic wr_rten;
  logic wr_ften;
  logic wr_swtrig;
  logic wr_pend;
  eil_lines_t wr_mask_bits;
  eil_lines_t wr_trig_bits;

  assign wr_imask = reg_wr && (reg_addr == OFF_IMASK);
  assign wr_emask = reg_wr && (reg_addr == OFF_EMASK);
  assign wr_rten = reg_wr && (reg_addr == OFF_RTEN);
  assign wr_ften = reg_wr && (reg_addr == OFF_FTEN);
  assign wr_swtrig = reg_wr && (reg_addr == OFF_SWTRIG);
  assign wr_pend = reg_wr && (reg_addr == OFF_PEND);
  assign wr_mask_bits = reg_wdata[NLINE-1:0] & MASK_BITS[NLINE-1:0];
  assign wr_trig_bits = reg_wdata[NLINE-1:0] & TRIG_BITS[NLINE-1:0];

  // Line causes
  logic trig_wr;
  eil_lines_t edge_hit;
  eil_lines_t hw_trig;
  eil_lines_t sw_fire;
  eil_lines_t cause;
  eil_lines_t irq_set;
  eil_lines_t clr_bits;
  eil_lines_t evt_only;
  logic evt_cause;

  // Either edge may trigger and wake-up lines fire on their rise; edges are
  // dropped while a trigger selection register is being written
  assign trig_wr = wr_rten || wr_ften;
  assign edge_hit = (line_rise & q.rten) | (line_fall & q.ften)
    | (line_rise & WAKE_BITS[NLINE-1:0]);
  assign hw_trig = trig_wr ? '0 : edge_hit;

  // Only a zero-to-one step of the software trigger fires
  assign sw_fire = wr_swtrig ? (wr_trig_bits & ~q.swtrig) : '0;

  assign cause = hw_trig | sw_fire;
  // Wake-up lines have no pending bit; they only give events
  assign irq_set = cause & q.imask & TRIG_BITS[NLINE-1:0];
  assign clr_bits = wr_pend ? wr_trig_bits : '0;
  assign evt_only = cause & q.emask & ~q.imask;
  assign evt_cause = |(cause & q.emask);

  always_comb begin
    next_q = q;
    if (wr_imask) begin
      next_q.imask = wr_mask_bits;
    end
    if (wr_emask) begin
      next_q.emask = wr_mask_bits;
    end
    if (wr_rten) begin
      next_q.rten = wr_trig_bits;
    end
    if (wr_ften) begin
      next_q.ften = wr_trig_bits;
    end
    // Software trigger bits drop with their pending clear
    next_q.swtrig = (q.swtrig & ~clr_bits) | sw_fire;
    // New cause wins over a clear in the same cycle
    next_q.pend = (q.pend & ~clr_bits) | irq_set;
    next_q.wake = |next_q.pend;
    next_q.evt = evt_cause;
    next_q.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_IMASK: next_q.rdata = {{(32-NLINE){1'b0}}, q.imask};
        OFF_EMASK: next_q.rdata = {{(32-NLINE){1'b0}}, q.emask};
        OFF_RTEN: next_q.rdata = {{(32-NLINE){1'b0}}, q.rten};
        OFF_FTEN: next_q.rdata = {{(32-NLINE){1'b0}}, q.ften};
        OFF_SWTRIG: next_q.rdata = {{(32-NLINE){1'b0}}, q.swtrig};
        OFF_PEND: next_q.rdata = {{(32-NLINE){1'b0}}, q.pend};
        default: next_q.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q.imask <= RST_IMASK[NLINE-1:0];
      q.emask <= RST_EMASK[NLINE-1:0];
      q.rten <= RST_RTEN[NLINE-1:0];
      q.ften <= RST_FTEN[NLINE-1:0];
      q.swtrig <= RST_SWTRIG[NLINE-1:0];
      q.pend <= RST_PEND[NLINE-1:0];
      q.rdata <= '0;
      q.wake <= 1'b0;
      q.evt <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  assign line_irq = q.pend;
  assign irq_wake = q.wake;
  assign event_pulse = q.evt;
  assign reg_rdata = q.rdata;

  pend_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (|irq_set) |=> ((q.pend & $past(irq_set)) == $past(irq_set)))
    else $error("unmasked cause did not set pending");

  pend_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_pend && ((clr_bits & ~irq_set) != '0))
    |=> ((q.pend & $past(clr_bits) & ~$past(irq_set)) == '0))
    else $error("pending write of one did not clear");

  pend_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 (($past(q.pend) & ~$past(clr_bits) & ~q.pend) == '0))
    else $error("pending bit lost without a clear");

  evt_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    evt_cause |=> event_pulse ##1 (event_pulse == $past(evt_cause)))
    else $error("event pulse missing or stretched");

  evt_no_pend_a: assert property (@(posedge clk_sys) disable iff (rst)
    (|evt_only) |=> ((q.pend & ~$past(q.pend) & $past(evt_only)) == '0))
    else $error("event-only line set pending");

  sw_event_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_swtrig && ((wr_trig_bits & ~q.swtrig & q.emask) != '0)) |=> event_pulse)
    else $error("software trigger gave no event");

  sw_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_swtrig && ((wr_trig_bits & ~q.swtrig & q.imask) != '0))
    |=> ((q.pend & q.swtrig) != '0))
    else $error("software trigger set no pending");

  mask_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 ((q.pend & ~$past(q.pend) & ~$past(q.imask)) == '0))
    else $error("masked line set pending");

  wake_any_a: assert property (@(posedge clk_sys) disable iff (rst)
    irq_wake == (|line_irq))
    else $error("wake output disagrees with pending");

  trig_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    trig_wr |=> ((q.pend & ~$past(q.pend)) == '0))
    else $error("edge taken during trigger write");

  reg_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && (reg_addr == OFF_PEND))
    |=> (reg_rdata == {{(32-NLINE){1'b0}}, $past(q.pend)}))
    else $error("pending readback wrong");

  read_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> (reg_rdata == 32'h0000_0000))
    else $error("read data outside read answer");

  imask_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_imask |=> (q.imask == $past(wr_mask_bits)))
    else $error("interrupt mask write not taken");

  emask_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_emask |=> (q.emask == $past(wr_mask_bits)))
    else $error("event mask write not taken");

  rten_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_rten |=> (q.rten == $past(wr_trig_bits)))
    else $error("rising enable write not taken");

  ften_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_ften |=> (q.ften == $past(wr_trig_bits)))
    else $error("falling enable write not taken");

  mask_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_imask |=> (q.imask == $past(q.imask)))
    else $error("interrupt mask changed without write");

  emask_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_emask |=> (q.emask == $past(q.emask)))
    else $error("event mask changed without write");

  edge_sel_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !trig_wr |=> ((q.rten == $past(q.rten)) && (q.ften == $past(q.ften))))
    else $error("edge selection changed without write");

  pend_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_pend |=> (((q.pend ^ $past(q.pend)) & ~$past(wr_trig_bits) & ~$past(irq_set)) == '0))
    else $error("pending write of zero changed a bit");

  pend_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
    ((q.rten | q.ften | q.swtrig | q.pend) & ~TRIG_BITS[NLINE-1:0]) == '0)
    else $error("unimplemented line bit set");

  evt_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    !evt_cause |=> !event_pulse)
    else $error("event pulse without cause");

  rise_evt_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!trig_wr && ((line_rise & q.rten & q.emask) != '0)) |=> event_pulse)
    else $error("rising edge gave no event");

  fall_evt_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!trig_wr && ((line_fall & q.ften & q.emask) != '0)) |=> event_pulse)
    else $error("falling edge gave no event");

  rise_pend_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!trig_wr && ((line_rise & q.rten & q.imask) != '0)) |=> (line_irq != '0))
    else $error("rising edge gave no request");

  fall_pend_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!trig_wr && ((line_fall & q.ften & q.imask) != '0)) |=> (line_irq != '0))
    else $error("falling edge gave no request");

  wake_evt_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!trig_wr && ((line_rise & WAKE_BITS[NLINE-1:0] & q.emask) != '0)) |=> event_pulse)
    else $error("wake-up line gave no event");

  sw_once_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_swtrig && ((wr_trig_bits & ~q.swtrig) == '0) && (hw_trig == '0)) |=> !event_pulse)
    else $error("repeated software trigger fired");

  sw_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 (($past(q.swtrig) & ~q.swtrig & ~$past(clr_bits)) == '0))
    else $error("software trigger lost without clear");

  sw_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_pend |=> ((q.swtrig & $past(clr_bits) & ~$past(sw_fire)) == '0))
    else $error("software trigger kept after clear");

  wake_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
    (|irq_set) |=> irq_wake)
    else $error("new request gave no wake");

  read_imask_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && (reg_addr == OFF_IMASK)) |=> (reg_rdata == {{(32-NLINE){1'b0}}, $past(q.imask)}))
    else $error("interrupt mask readback wrong");

  read_emask_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && (reg_addr == OFF_EMASK)) |=> (reg_rdata == {{(32-NLINE){1'b0}}, $past(q.emask)}))
    else $error("event mask readback wrong");

  read_rten_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && (reg_addr == OFF_RTEN)) |=> (reg_rdata == {{(32-NLINE){1'b0}}, $past(q.rten)}))
    else $error("rising enable readback wrong");

  read_ften_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && (reg_addr == OFF_FTEN)) |=> (reg_rdata == {{(32-NLINE){1'b0}}, $past(q.ften)}))
    else $error("falling enable readback wrong");

  read_swtrig_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && (reg_addr == OFF_SWTRIG)) |=> (reg_rdata == {{(32-NLINE){1'b0}}, $past(q.swtrig)}))
    else $error("software trigger readback wrong");

  read_unmap_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && (reg_addr > OFF_PEND)) |=> (reg_rdata == 32'h0000_0000))
    else $error("unmapped read not zero");
endmodule

// ---- sim/eil_core_model.sv ----
`timescale 1ns/1ns
module eil_core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic event_pulse,
  input wire logic irq_wake,
  output int ev_count,
  output logic irq_woken
);
  // Counts wake pulses; an event wake leaves nothing to clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ev_count <= 0;
      irq_woken <= 1'b0;
    end else begin
      if (event_pulse === 1'b1) begin
        ev_count <= ev_count + 1;
      end
      if (irq_wake === 1'b1) begin
        irq_woken <= 1'b1;
      end
    end
  end
endmodule

// ---- sim/tb_eil_controller.sv ----
`timescale 1ns/1ns
module tb_eil_controller;
  import eil_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic [NPIN-1:0] pin [5] = '{default: '0};
  logic [NPIN*SEL_W-1:0] port_select = '0;
  logic [7:0] isrc = '0;
  eil_lines_t line_irq;
  logic irq_wake;
  logic event_pulse;
  logic irq_woken;
  int ev_count;
  int e0;
  int failures = 0;
  int n_compared = 0;
  int ln [5] = '{16, 17, 19, 21, 22};

  always #5 clk_sys = ~clk_sys;

  eil_controller dut_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_pins(pin[0]), .port_b_pins(pin[1]), .port_c_pins(pin[2]),
    .port_d_pins(pin[3]), .port_f_pins(pin[4]), .port_select(port_select),
    .supply_monitor_output(isrc[0]), .clock_alarm(isrc[1]), .tamper_stamp(isrc[2]),
    .first_comparator(isrc[3]), .second_comparator(isrc[4]), .i2c_wake(isrc[5]),
    .usart_wake(isrc[6]), .consumer_control_wake(isrc[7]), .line_irq(line_irq),
    .irq_wake(irq_wake), .event_pulse(event_pulse)
  );

  eil_core_model core_u (
    .clk_sys(clk_sys), .rst(rst), .event_pulse(event_pulse), .irq_wake(irq_wake),
    .ev_count(ev_count), .irq_woken(irq_woken)
  );

  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Bounded wait for a request line to reach a level
  task wait_irq(input int i, input logic lvl);
    int k;
    for (k = 0; k < 20 && line_irq[i] !== lvl; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({31'h0, line_irq[i]}, {31'h0, lvl}, "request line level");
    if (k == 20) begin
      report_and_stop;
    end
  endtask

  task settle;
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int r = 0; r < 6; r++) begin
      rd(8'(r * 4), d);
      chk(d, (r == 0) ? RST_IMASK : 32'h0000_0000, "reset value");
    end
    rd(8'h18, d);
    chk(d, 32'h0000_0000, "unmapped read");
    wr(OFF_RTEN, 32'hffff_ffff);
    rd(OFF_RTEN, d);
    chk(d, TRIG_BITS, "rising enable bits");
    wr(OFF_IMASK, 32'hffff_ffff);
    rd(OFF_IMASK, d);
    chk(d, MASK_BITS, "mask bits");
    $display("register map test done");
    // Line 3 from each port in turn, rising edge only
    wr(OFF_IMASK, 32'h0000_0008);
    wr(OFF_RTEN, 32'h0000_0008);
    for (int p = 0; p < 5; p++) begin
      @(posedge clk_sys);
      port_select[11:9] <= 3'(p);
      pin[p][3] <= 1'b1;
      wait_irq(3, 1'b1);
      chk({31'h0, irq_wake}, 32'h0000_0001, "wake level");
      @(posedge clk_sys);
      pin[p][3] <= 1'b0;
      wr(OFF_PEND, 32'h0000_0000);
      rd(OFF_PEND, d);
      chk(d, 32'h0000_0008, "pending held");
      wr(OFF_PEND, 32'h0000_0008);
      wait_irq(3, 1'b0);
    end
    chk({31'h0, irq_woken}, 32'h0000_0001, "core woken");
    // Rise reaches the detector in the cycle of a trigger-register write
    @(posedge clk_sys);
    pin[4][3] <= 1'b1;
    @(posedge clk_sys);
    wr(OFF_FTEN, 32'h0000_0000);
    settle;
    rd(OFF_PEND, d);
    chk(d, 32'h0000_0000, "edge during trigger write");
    @(posedge clk_sys);
    pin[4][3] <= 1'b0;
    $display("hardware interrupt test done");
    wr(OFF_IMASK, 32'h0000_0000);
    wr(OFF_EMASK, 32'h0000_0020);
    wr(OFF_RTEN, 32'h0000_0000);
    wr(OFF_FTEN, 32'h0000_0020);
    e0 = ev_count;
    @(posedge clk_sys);
    pin[0][5] <= 1'b1;
    settle;
    pin[0][5] <= 1'b0;
    settle;
    chk(32'(ev_count - e0), 32'h0000_0001, "falling event count");
    rd(OFF_PEND, d);
    chk(d, 32'h0000_0000, "no pending after event");
    wr(OFF_RTEN, 32'h0000_0020);
    e0 = ev_count;
    pin[0][5] <= 1'b1;
    settle;
    pin[0][5] <= 1'b0;
    settle;
    chk(32'(ev_count - e0), 32'h0000_0002, "both edge count");
    $display("hardware event test done");
    wr(OFF_EMASK, 32'h0000_0010);
    e0 = ev_count;
    wr(OFF_SWTRIG, 32'h0000_0010);
    settle;
    chk(32'(ev_count - e0), 32'h0000_0001, "software event count");
    rd(OFF_PEND, d);
    chk(d, 32'h0000_0000, "no pending after soft event");
    wr(OFF_PEND, 32'h0000_0010);
    wr(OFF_IMASK, 32'h0000_0040);
    wr(OFF_SWTRIG, 32'h0000_0040);
    wait_irq(6, 1'b1);
    wr(OFF_PEND, 32'h0000_0040);
    wait_irq(6, 1'b0);
    rd(OFF_SWTRIG, d);
    chk(d, 32'h0000_0000, "soft trigger cleared");
    $display("software trigger test done");
    wr(OFF_EMASK, 32'h0000_0000);
    wr(OFF_IMASK, 32'h006b_0000);
    wr(OFF_RTEN, 32'h006b_0000);
    wr(OFF_FTEN, 32'h0000_0000);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      isrc[k] <= 1'b1;
      wait_irq(ln[k], 1'b1);
      chk({4'h0, line_irq}, 32'h0000_0001 << ln[k], "internal line");
      wr(OFF_PEND, 32'h0000_0001 << ln[k]);
      wait_irq(ln[k], 1'b0);
    end
    wr(OFF_EMASK, WAKE_BITS);
    e0 = ev_count;
    for (int k = 5; k < 8; k++) begin
      @(posedge clk_sys);
      isrc[k] <= 1'b1;
      settle;
      chk(32'(ev_count - e0), 32'(k - 4), "wake line event count");
    end
    rd(OFF_PEND, d);
    chk(d, 32'h0000_0000, "no pending from wake lines");
    $display("internal line test done");
    report_and_stop;
  end
endmodule
